// File: oswc_pkg.sv
// Package for the output switching count alarm block.
// Assumes a 10 MHz APB clock; shared by the top module and its count memory.
package oswc_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CONFIG     = 8'h00;  // Output types, routing, display enables.
    localparam logic [7:0] ADDR_THRESH1    = 8'h04;  // Output 1 alarm threshold.
    localparam logic [7:0] ADDR_THRESH2    = 8'h08;  // Output 2 alarm threshold.
    localparam logic [7:0] ADDR_MONITOR1   = 8'h0C;  // Output 1 count monitor.
    localparam logic [7:0] ADDR_MONITOR2   = 8'h10;  // Output 2 count monitor.
    localparam logic [7:0] ADDR_CLEAR      = 8'h14;  // Counter clear selection (write).
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;  // Sticky events, cleared on read.
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h1C;  // Interrupt mask, same layout.

    // ----------------------------------------------------------------
    // Configuration register fields
    // ----------------------------------------------------------------
    localparam int CFG_TYPE1_LSB   = 0;  // Two bits: output 1 type.
    localparam int CFG_TYPE2_LSB   = 2;  // Two bits: output 2 type.
    localparam int CFG_AUX1_BIT    = 4;  // Route alarm 1 to aux output.
    localparam int CFG_AUX2_BIT    = 5;  // Route alarm 2 to aux output.
    localparam int CFG_DISP1_BIT   = 6;  // Show alarm 1 on display.
    localparam int CFG_DISP2_BIT   = 7;  // Show alarm 2 on display.
    localparam int CFG_WIDTH       = 8;

    // Output type codes.
    localparam logic [1:0] TYPE_RELAY      = 2'h0;
    localparam logic [1:0] TYPE_VOLT_DRIVE = 2'h1;
    localparam logic [1:0] TYPE_SOLID      = 2'h2;
    localparam logic [1:0] TYPE_LINEAR     = 2'h3;

    // Interrupt status bit layout.
    localparam int IRQ_ALARM1_BIT  = 0;
    localparam int IRQ_ALARM2_BIT  = 1;
    localparam int IRQ_WIDTH       = 2;

    // ----------------------------------------------------------------
    // Counting constants and reset values
    // ----------------------------------------------------------------
    localparam int           VAL_WIDTH      = 14;
    localparam logic [13:0]  VAL_MAX        = 14'h270F;  // 9999 units.
    localparam logic [6:0]   UNIT_OPS       = 7'h64;     // 100 operations per unit.
    localparam logic [13:0]  THRESH_RESET   = 14'h0000;
    localparam logic [7:0]   CONFIG_RESET   = 8'h00;
    localparam logic [1:0]   MASK_RESET     = 2'h0;

    // Bus state machine states.
    typedef enum logic [1:0] {
        OSWC_IDLE,
        OSWC_ACCESS,
        OSWC_DONE
    } oswc_bus_state_t;

endpackage : oswc_pkg

// File: oswc_count_mem.sv
// Small two-entry store for the reported counts in hundred-operation units.
// Assumes a single clock; read data comes out of a register.
`timescale 1ns/1ps
module oswc_count_mem
#(
    parameter int WIDTH = 14,
    parameter int DEPTH = 2
)
(
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]         wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [WIDTH-1:0]         rd_data
);
    import oswc_pkg::*;

    // --------------------------------------------------------------
    // Storage state
    // --------------------------------------------------------------
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;   // Stored counts.
        logic [WIDTH-1:0]            rdata; // Registered read data.
    } oswc_mem_state_t;

    oswc_mem_state_t state;       // Registered state.
    oswc_mem_state_t next_state;  // Next value.

    // Read first: a read returns the old content; callers tolerate one cycle of lag.
    always_comb
    begin
        next_state = state;
        if (wr_en)
        begin
            next_state.mem[wr_addr] = wr_data;
        end
        next_state.rdata = state.mem[rd_addr];
    end

    // Registers clear to zero so every count starts from nothing.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign rd_data = state.rdata;

endmodule : oswc_count_mem

// File: oswc_top.sv
// Switching count alarm for two switched control outputs, with APB registers.
// Assumes the output drive levels come from outside the pclk domain.
//
// Contract
// - Count only relay, voltage-drive, solid-state outputs.
// - Hide monitor for linear outputs.
// - Hide output 2 monitor while threshold zero.
// - Alarm when count exceeds threshold.
// - Zero threshold disables alarm; resets zero.
// - Alarm routable to aux output and display.
// - Clear function clears selected output counters.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module oswc_top
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        out1_drive,
    input  wire logic        out2_drive,
    output logic             aux1_alarm,
    output logic             aux2_alarm,
    output logic             disp1_alarm,
    output logic             disp2_alarm,
    output logic             irq
);
    import oswc_pkg::*;

    // --------------------------------------------------------------
    // State of the block
    // --------------------------------------------------------------
    typedef struct packed {
        logic [1:0]              sync1;     // First synchroniser stage.
        logic [1:0]              sync2;     // Second synchroniser stage.
        logic [1:0]              prev;      // Previous synchronised level.
        logic [1:0][6:0]         raw;       // Sub-unit operation counts.
        logic [1:0][VAL_WIDTH-1:0] units;   // Counts in hundred units.
        logic [1:0][VAL_WIDTH-1:0] thresh;  // Alarm thresholds.
        logic [CFG_WIDTH-1:0]    config_q;  // Type, routing, display bits.
        logic [IRQ_WIDTH-1:0]    status;    // Sticky alarm events.
        logic [IRQ_WIDTH-1:0]    mask;      // Interrupt mask.
        logic [1:0]              alarm;     // Current alarm levels.
        logic [31:0]             rdata;     // APB read data.
        logic                    ready;     // APB ready.
        logic                    err;       // APB error.
        logic [3:0]              outs;      // Aux and display outputs.
        logic                    irq_q;     // Interrupt output.
    } oswc_state_t;

    oswc_state_t state;       // Registered state.
    oswc_state_t next_state;  // Next value.

    logic [VAL_WIDTH-1:0] mem_rdata;  // Registered old content of the mirror entry at mem_sel.
    logic                 mem_wr;     // Mirror write strobe.
    logic                 mem_sel;    // Mirror write index.

    // --------------------------------------------------------------
    // Helper functions
    // --------------------------------------------------------------

    // True for a switched output type; a linear output is never counted.
    function automatic logic is_switched(input logic [1:0] kind);
        is_switched = (kind != TYPE_LINEAR);
    endfunction : is_switched

    // Monitor visibility: hidden for linear type or, on output 2, zero threshold.
    function automatic logic monitor_visible(input logic [1:0] kind,
                                             input logic       second,
                                             input logic [VAL_WIDTH-1:0] th);
        monitor_visible = is_switched(kind) && !(second && th == '0);
    endfunction : monitor_visible

    // APB register decode: true when the address names a mapped word.
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == ADDR_CONFIG) || (a == ADDR_THRESH1) || (a == ADDR_THRESH2) ||
                      (a == ADDR_MONITOR1) || (a == ADDR_MONITOR2) || (a == ADDR_CLEAR) ||
                      (a == ADDR_IRQ_STATUS) || (a == ADDR_IRQ_MASK);
    endfunction : addr_mapped

    // --------------------------------------------------------------
    // Next-state logic
    // --------------------------------------------------------------

    // Counting, alarms, bus access and interrupts all resolve here.
    // The bus answers with pready high in the cycle after the first access cycle.
    always_comb
    begin
        logic [1:0] kind [2];
        logic [1:0] clear_sel;
        logic [1:0] rise;
        logic       acc;
        next_state = state;
        kind[0]    = state.config_q[CFG_TYPE1_LSB +: 2];
        kind[1]    = state.config_q[CFG_TYPE2_LSB +: 2];
        clear_sel  = 2'h0;
        rise       = 2'h0;
        acc        = psel && penable && !state.ready;

        // Two flip-flops before any logic looks at the drive pins.
        next_state.sync1 = {out2_drive, out1_drive};
        next_state.sync2 = state.sync1;
        next_state.prev  = state.sync2;

        // Bus handshake: one cycle of pready per access.
        next_state.ready = acc;
        next_state.err   = acc && !addr_mapped(paddr);
        if (acc && !pwrite)
        begin
            case (paddr)
                ADDR_CONFIG:     next_state.rdata = {24'h00_0000, state.config_q};
                ADDR_THRESH1:    next_state.rdata = {18'h0_0000, state.thresh[0]};
                ADDR_THRESH2:    next_state.rdata = {18'h0_0000, state.thresh[1]};
                // Hidden monitors read as zero.
                ADDR_MONITOR1:   next_state.rdata = monitor_visible(kind[0], 1'b0, state.thresh[0]) ?
                                                    {18'h0_0000, state.units[0]} : 32'h0000_0000;
                ADDR_MONITOR2:   next_state.rdata = monitor_visible(kind[1], 1'b1, state.thresh[1]) ?
                                                    {18'h0_0000, state.units[1]} : 32'h0000_0000;
                ADDR_IRQ_STATUS: next_state.rdata = {30'h0000_0000, state.status};
                ADDR_IRQ_MASK:   next_state.rdata = {30'h0000_0000, state.mask};
                default:         next_state.rdata = 32'h0000_0000;
            endcase
        end
        else if (acc)
        begin
            next_state.rdata = 32'h0000_0000;
        end

        // Register writes.
        if (acc && pwrite)
        begin
            case (paddr)
                ADDR_CONFIG:   next_state.config_q = pwdata[CFG_WIDTH-1:0];
                // Thresholds above the range are held at the top value.
                ADDR_THRESH1:  next_state.thresh[0] = (pwdata[VAL_WIDTH-1:0] > VAL_MAX || pwdata[31:VAL_WIDTH] != '0)
                                                      ? VAL_MAX : pwdata[VAL_WIDTH-1:0];
                ADDR_THRESH2:  next_state.thresh[1] = (pwdata[VAL_WIDTH-1:0] > VAL_MAX || pwdata[31:VAL_WIDTH] != '0)
                                                      ? VAL_MAX : pwdata[VAL_WIDTH-1:0];
                ADDR_CLEAR:    clear_sel = pwdata[1:0];
                ADDR_IRQ_MASK: next_state.mask = pwdata[IRQ_WIDTH-1:0];
                default:       clear_sel = 2'h0;
            endcase
        end

        // Status clears on read; set below wins over this clear.
        if (acc && !pwrite && paddr == ADDR_IRQ_STATUS)
        begin
            next_state.status = '0;
        end

        // Per-output counting, clear and alarm.
        for (int i = 0; i < 2; i++)
        begin
            rise[i] = state.sync2[i] && !state.prev[i] && is_switched(kind[i]);
            if (clear_sel[i])
            begin
                // Clear drops both the unit count and the partial hundred.
                next_state.raw[i]   = 7'h00;
                next_state.units[i] = '0;
            end
            else if (rise[i] && state.units[i] != VAL_MAX)
            begin
                // Once capped the count stays at the top; it never wraps.
                if (state.raw[i] == UNIT_OPS - 7'h01)
                begin
                    next_state.raw[i]   = 7'h00;
                    next_state.units[i] = state.units[i] + 14'h0001;
                end
                else
                begin
                    next_state.raw[i] = state.raw[i] + 7'h01;
                end
            end
            // Zero threshold disables the alarm entirely.
            next_state.alarm[i] = (state.thresh[i] != '0) && (state.units[i] > state.thresh[i]);
            if (next_state.alarm[i] && !state.alarm[i])
            begin
                next_state.status[i] = 1'b1;
            end
        end

        // Routing of alarms to aux and display outputs.
        next_state.outs[0] = state.alarm[0] && state.config_q[CFG_AUX1_BIT];
        next_state.outs[1] = state.alarm[1] && state.config_q[CFG_AUX2_BIT];
        next_state.outs[2] = state.alarm[0] && state.config_q[CFG_DISP1_BIT];
        next_state.outs[3] = state.alarm[1] && state.config_q[CFG_DISP2_BIT];
        next_state.irq_q   = |(next_state.status & state.mask);
    end

    // --------------------------------------------------------------
    // State registers
    // --------------------------------------------------------------

    // Reset loads constants only; thresholds start at zero, alarms off.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state          <= '0;
            state.thresh   <= {THRESH_RESET, THRESH_RESET};
            state.config_q <= CONFIG_RESET;
            state.mask     <= MASK_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    // --------------------------------------------------------------
    // Count mirror memory
    // --------------------------------------------------------------

    // Mirrors count updates, only output 2's when both change in one cycle; kept for later read-back expansion.
    assign mem_wr  = (next_state.units[0] != state.units[0]) || (next_state.units[1] != state.units[1]);
    assign mem_sel = (next_state.units[1] != state.units[1]);

    oswc_count_mem #(
        .WIDTH (VAL_WIDTH),
        .DEPTH (2)
    ) u_mem (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (mem_wr),
        .wr_addr (mem_sel),
        .wr_data (next_state.units[mem_sel]),
        .rd_addr (mem_sel),
        .rd_data (mem_rdata)
    );

    // --------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // --------------------------------------------------------------
    assign prdata      = state.rdata;
    assign pready      = state.ready;
    assign pslverr     = state.err;
    assign aux1_alarm  = state.outs[0];
    assign aux2_alarm  = state.outs[1];
    assign disp1_alarm = state.outs[2];
    assign disp2_alarm = state.outs[3];
    assign irq         = state.irq_q;

endmodule : oswc_top

// File: oswc_assertions.sv
// Concurrent checks on the ports of the switching count alarm block.
// Bound to every oswc_top instance; it sees the top ports only.
`timescale 1ns/1ps
module oswc_assertions
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        aux1_alarm,
    input wire logic        aux2_alarm,
    input wire logic        irq
);
    import oswc_pkg::*;
    // ----------------------------------------------------------------
    // Helper logic and properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       done;     // A transfer completes at this edge.
    logic       clr_hit;  // A status read or a mask write completes.
    logic       mon_rd;   // A monitor read completes.
    logic [3:0] age_wr;   // Edges since the last write, saturating.
    logic [3:0] age_clr;  // Edges since the last clr_hit, saturating.
    assign done    = psel && penable && pready;
    assign clr_hit = done && (pwrite ? paddr == ADDR_IRQ_MASK : paddr == ADDR_IRQ_STATUS);
    assign mon_rd  = done && !pwrite && (paddr == ADDR_MONITOR1 || paddr == ADDR_MONITOR2);
    // Counts only grow, so an alarm or irq may fall only shortly after software acts.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            age_wr  <= 4'hF;
            age_clr <= 4'hF;
        end
        else
        begin
            age_wr  <= (done && pwrite) ? 4'h0 : age_wr + 4'(age_wr != 4'hF);
            age_clr <= clr_hit ? 4'h0 : age_clr + 4'(age_clr != 4'hF);
        end
    end
    sequence s_setup_access;
        psel && !penable ##1 psel && penable;
    endsequence
    a_ready_after_access: assert property (s_setup_access |=> pready)
        else $error("pready did not follow the access phase");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_error_on_unmapped: assert property (pready |-> pslverr == (paddr > ADDR_IRQ_MASK))
        else $error("pslverr does not match the address map");
    a_error_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("refused read returned data");
    a_monitor_in_range: assert property (mon_rd |-> prdata <= 32'(VAL_MAX))
        else $error("monitor beyond its range");
    a_alarm_falls_write: assert property ($fell(aux1_alarm) || $fell(aux2_alarm) |-> age_wr <= 4'h4)
        else $error("alarm fell without a register write");
    // A status read clears irq at the access edge, so irq is already low when that read completes.
    a_irq_falls_clear: assert property ($fell(irq) |-> clr_hit || age_clr <= 4'h3)
        else $error("irq fell without a status read or mask write");
    a_reset_quiet: assert property ($rose(presetn) |-> !irq && !aux1_alarm && !aux2_alarm)
        else $error("alarm or irq active after reset");
endmodule : oswc_assertions
bind oswc_top oswc_assertions i_oswc_assertions (.*);

// File: oswc_switch_stage.sv
// Model of the relay or solid-state stage that switches both outputs.
// Assumes pulse() is called just after a rising edge of pclk.
`timescale 1ns/1ps
module oswc_switch_stage
(
    input  wire logic pclk,
    output logic      out1_drive,
    output logic      out2_drive
);
    logic [1:0] level = 2'h0;  // Drive level per output, high means on.
    assign out1_drive = level[0];
    assign out2_drive = level[1];
    // Each operation is on for two cycles and off for one or two, so every
    // edge outlasts the input synchroniser; shorter glitches are not modelled.
    task automatic pulse(input int ch, input int n);
        for (int k = 0; k < n; k++)
        begin
            level[ch] <= 1'b1;
            repeat (2) @(posedge pclk);
            level[ch] <= 1'b0;
            repeat (1 + k % 2) @(posedge pclk);
        end
        repeat (8) @(posedge pclk);
    endtask : pulse
endmodule : oswc_switch_stage

// File: test_output_switch_count_alarm.sv
// Self-checking bench for the switching count alarm block.
// Assumes the switching stage model drives the outputs and the checker is bound.
`timescale 1ns/1ps
module test_output_switch_count_alarm;
    import oswc_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr  = 8'h00;          // Byte address of the transfer.
    logic [31:0] pwdata = 32'h0000_0000;  // Write data of the transfer.
    logic [31:0] prdata, v;               // Read data; a random threshold.
    logic [7:0]  cfg;                     // Configuration under test.
    logic        pready, pslverr, out1_drive, out2_drive, aux1_alarm, aux2_alarm, disp1_alarm, disp2_alarm, irq;
    int          miscompares = 0, n_checks = 0, seed = 41003;
    always #50 pclk = ~pclk;
    oswc_top i_oswc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .out1_drive(out1_drive), .out2_drive(out2_drive), .aux1_alarm(aux1_alarm), .aux2_alarm(aux2_alarm),
        .disp1_alarm(disp1_alarm), .disp2_alarm(disp2_alarm), .irq(irq));
    oswc_switch_stage i_oswc_switch_stage (.pclk(pclk), .out1_drive(out1_drive), .out2_drive(out2_drive));
    // ----------------------------------------------------------------
    // Expectations, comparison and bus tasks
    // ----------------------------------------------------------------
    // Alarm level for a count and a threshold, both in hundred units.
    function automatic logic [31:0] exp_alarm(input int units, input int th);
        return 32'(th != 0 && units > th);
    endfunction : exp_alarm
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("%0d checks, %0d mismatches", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    // One APB transfer; reads compare data, all compare pslverr with the map.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int w = 0; pready !== 1'b1; w++)
        begin
            if (w == 20)
            begin
                miscompares++;
                finish_test();
            end
            @(posedge pclk);
        end
        if (!wr)
            check(prdata, exp);
        check(32'(pslverr), 32'(a > ADDR_IRQ_MASK));
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 32'h0000_0000);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000, exp);
    endtask : rd
    // Main sequence: reset, map, thresholds, types, alarms, irq, clear.
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 8; i++)
            rd(8'(4 * i), 32'h0000_0000);
        wr(8'h20, 32'h0000_0001);
        rd(8'(8'h20 + 4 * ($unsigned($random(seed)) % 8)), 32'h0000_0000);
        repeat (4)
        begin
            v = $unsigned($random(seed)) % 10000;
            wr(ADDR_THRESH1, v);
            rd(ADDR_THRESH1, v);
        end
        wr(ADDR_THRESH1, 32'(VAL_MAX));
        rd(ADDR_THRESH1, 32'(VAL_MAX));
        // Every output type; the count restarts before each one.
        for (int t = 0; t < 4; t++)
        begin
            wr(ADDR_CONFIG, 32'(t));
            wr(ADDR_CLEAR, 32'h0000_0001);
            i_oswc_switch_stage.pulse(0, 100);
            rd(ADDR_MONITOR1, 32'(2'(t) != TYPE_LINEAR));
        end
        wr(ADDR_CONFIG, 32'(TYPE_RELAY));
        rd(ADDR_MONITOR1, 32'h0000_0000);
        cfg = {3'($random(seed)), 1'b1, TYPE_SOLID, TYPE_RELAY};
        wr(ADDR_CONFIG, 32'(cfg));
        wr(ADDR_THRESH1, 32'h0000_0001);
        wr(ADDR_THRESH2, 32'h0000_0001);
        wr(ADDR_IRQ_MASK, 32'h0000_0003);
        i_oswc_switch_stage.pulse(0, 100);
        check(32'(aux1_alarm), exp_alarm(1, 1));
        i_oswc_switch_stage.pulse(0, 100);
        rd(ADDR_MONITOR1, 32'h0000_0002);
        check(32'(aux1_alarm), exp_alarm(2, 1));
        check(32'(disp1_alarm), exp_alarm(2, 1) & 32'(cfg[CFG_DISP1_BIT]));
        check(32'(irq), 32'h0000_0001);
        rd(ADDR_IRQ_STATUS, 32'h0000_0001);
        rd(ADDR_IRQ_STATUS, 32'h0000_0000);
        check(32'(irq), 32'h0000_0000);
        i_oswc_switch_stage.pulse(1, 200);
        rd(ADDR_MONITOR2, 32'h0000_0002);
        check(32'(aux2_alarm), exp_alarm(2, 1) & 32'(cfg[CFG_AUX2_BIT]));
        check(32'(disp2_alarm), exp_alarm(2, 1) & 32'(cfg[CFG_DISP2_BIT]));
        rd(ADDR_IRQ_STATUS, 32'h0000_0002);
        wr(ADDR_THRESH2, 32'h0000_0000);
        rd(ADDR_MONITOR2, 32'h0000_0000);
        check(32'(aux2_alarm | disp2_alarm), exp_alarm(2, 0));
        // A masked event still sets its status bit but leaves irq low.
        wr(ADDR_IRQ_MASK, 32'h0000_0001);
        wr(ADDR_THRESH2, 32'h0000_0001);
        rd(ADDR_MONITOR2, 32'h0000_0002);
        check(32'(irq), 32'h0000_0000);
        rd(ADDR_IRQ_STATUS, 32'h0000_0002);
        wr(ADDR_CLEAR, 32'h0000_0003);
        rd(ADDR_MONITOR1, 32'h0000_0000);
        rd(ADDR_MONITOR2, 32'h0000_0000);
        check(32'(aux1_alarm), 32'h0000_0000);
        finish_test();
    end
endmodule : test_output_switch_count_alarm
